// ==== rtl/exec_pkg.sv ====
package exec_pkg;

	typedef enum logic [2:0] {
		op_none               = 3'h0,
		bcd_adjust_op         = 3'h1,
		minus_one_byte_op     = 3'h2,
		minus_one_word_op     = 3'h3,
		interrupt_off_op      = 3'h4,
		divide_op             = 3'h5,
		count_loop_branch_op  = 3'h6
	} op_t;

	typedef enum logic [1:0] {
		st_idle = 2'h0,
		st_run  = 2'h1
	} exec_st_t;

	////////////////////////////////////////////////////////////////////
	localparam logic [7:0] OPC_DA_R     = 8'h40;
	localparam logic [7:0] OPC_DA_IR    = 8'h41;
	localparam logic [7:0] OPC_DEC_R    = 8'h00;
	localparam logic [7:0] OPC_DEC_IR   = 8'h01;
	localparam logic [7:0] OPC_MINUS_ONE_WORD_OP_RR  = 8'h80;
	localparam logic [7:0] OPC_MINUS_ONE_WORD_OP_IR  = 8'h81;
	localparam logic [7:0] OPC_IOFF     = 8'h8f;
	localparam logic [7:0] OPC_DIV_R    = 8'h94;
	localparam logic [7:0] OPC_DIV_IR   = 8'h95;
	localparam logic [7:0] OPC_DIV_IM   = 8'h96;
	localparam logic [3:0] OPC_LOOP_LO  = 4'ha;

	localparam logic [4:0] CYC_BYTE     = 5'h04;
	localparam logic [4:0] CYC_WORD     = 5'h08;
	localparam logic [4:0] CYC_IOFF     = 5'h04;
	localparam logic [4:0] CYC_DIV      = 5'h1a;
	localparam logic [4:0] CYC_DIV0     = 5'h0a;
	localparam logic [4:0] CYC_LOOP     = 5'h08;
	localparam logic [4:0] CNT_STEP     = 5'h01;
	localparam logic [4:0] CNT_ZERO     = 5'h00;

	localparam logic [1:0] LEN_1        = 2'h1;
	localparam logic [1:0] LEN_2        = 2'h2;
	localparam logic [1:0] LEN_3        = 2'h3;

	////////////////////////////////////////////////////////////////////
	localparam logic [7:0] ADDR_CMD     = 8'h00;
	localparam logic [7:0] ADDR_DST     = 8'h04;
	localparam logic [7:0] ADDR_SRC     = 8'h08;
	localparam logic [7:0] ADDR_FLAGS   = 8'h0c;
	localparam logic [7:0] ADDR_PC      = 8'h10;
	localparam logic [7:0] ADDR_MODE    = 8'h14;
	localparam logic [7:0] ADDR_PEND    = 8'h18;
	localparam logic [7:0] ADDR_STATUS  = 8'h1c;

	localparam int unsigned FLAG_C      = 7;
	localparam int unsigned FLAG_Z      = 6;
	localparam int unsigned FLAG_S      = 5;
	localparam int unsigned FLAG_V      = 4;
	localparam int unsigned FLAG_D      = 3;
	localparam int unsigned FLAG_H      = 2;
	localparam int unsigned MODE_GIE    = 0;
	localparam logic [7:0] MODE_RESET   = 8'h00;

	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	////////////////////////////////////////////////////////////////////
	localparam logic [7:0] ADJ_00       = 8'h00;
	localparam logic [7:0] ADJ_06       = 8'h06;
	localparam logic [7:0] ADJ_60       = 8'h60;
	localparam logic [7:0] ADJ_66       = 8'h66;
	localparam logic [7:0] ADJ_FA       = 8'hfa;
	localparam logic [7:0] ADJ_A0       = 8'ha0;
	localparam logic [7:0] ADJ_9A       = 8'h9a;
	localparam logic [3:0] NIB_2        = 4'h2;
	localparam logic [3:0] NIB_3        = 4'h3;
	localparam logic [3:0] NIB_6        = 4'h6;
	localparam logic [3:0] NIB_7        = 4'h7;
	localparam logic [3:0] NIB_8        = 4'h8;
	localparam logic [3:0] NIB_9        = 4'h9;
	localparam logic [3:0] NIB_A        = 4'ha;
	localparam logic [7:0] BYTE_MIN     = 8'h80;
	localparam logic [15:0] WORD_MIN    = 16'h8000;
	localparam logic [15:0] QUO_OVF     = 16'h0100;
	localparam logic [15:0] QUO_CARRY   = 16'h0200;

endpackage

// ==== rtl/cpu_bcd_dec_div_loop_exec.sv ====
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ns

// Functional notes
// - after add, decimal adjust adds 00, 06, 60 or 66 per carry, nibbles, half-carry.
// - after subtract, decimal adjust adds 00, FA, A0 or 9A per carry, half-carry, nibbles.
// - decimal adjust carry follows the selected case's carry-after, else cleared.
// - decimal adjust sets zero and sign from result; decimal and half-carry unchanged.
// - decimal adjust opcodes 40 and 41, two bytes, four cycles.
// - byte decrement subtracts one, opcodes 00 and 01, two bytes, four cycles.
// - byte decrement sets zero, sign, overflow; carry, decimal, half-carry untouched.
// - word decrement subtracts one from 16-bit pair, opcodes 80 and 81, eight cycles.
// - word decrement updates zero, sign, overflow from 16 bits; others unchanged.
// - interrupt-off clears global enable bit 0, opcode 8F, one byte, four cycles.
// - with interrupts off, requests still set pending bits but none is serviced.
// - divide 16-bit destination by 8-bit source; quotient low, remainder high.
// - overflow set when quotient reaches 2^8 or divisor is zero.
// - divide carry set only with overflow and quotient in 2^8 to 2^9-1.
// - divide zero on zero divisor or quotient, sign from quotient bit 7, cleared on zero divisor.
// - divide opcodes 94, 95, 96, three bytes; 10 cycles on zero divisor, else 26.
// - loop branch decrements counter, adds offset if nonzero, eight cycles, no flags.
// - loop offset is signed -128..+127 from address of the following byte.
module cpu_bcd_dec_div_loop_exec (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address and data
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// axi4-lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// axi4-lite read
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// core side
	input  wire logic [7:0]  irq_request,
	output logic             irq_service,
	output logic             exec_busy,
	output logic             exec_done
);

	typedef struct packed {
		exec_pkg::exec_st_t st;
		logic [4:0]         cnt;
		exec_pkg::op_t      op;
		logic [15:0]        dst;
		logic [7:0]         src;
		logic [15:0]        pc;
		logic [7:0]         flags;
		logic [7:0]         mode;
		logic [7:0]         pend;
		logic               illegal;
		logic [1:0]         len;
		logic               done;
		logic               bvalid;
		logic [1:0]         bresp;
		logic               rvalid;
		logic [31:0]        rdata;
		logic [1:0]         rresp;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic        wr_go;
	logic        rd_go;
	logic        commit;
	logic        start;
	logic [31:0] wmerge;
	logic [3:0]  hi;
	logic [3:0]  lo;
	logic [7:0]  adj;
	logic        adj_c;
	logic [7:0]  byte_res;
	logic [15:0] word_res;
	logic [7:0]  divisor;
	logic [15:0] quo;
	logic [15:0] rem;
	logic [7:0]  da_res;
	logic [15:0] jump_pc;

	////////////////////////////////////////////////////////////////////
	// write and read both wait for the previous answer to be taken
	assign wr_go   = awvalid && wvalid && !s_q.bvalid;
	assign rd_go   = arvalid && !s_q.rvalid;
	assign awready = wr_go;
	assign wready  = wr_go;
	assign arready = !s_q.rvalid;
	assign bvalid  = s_q.bvalid;
	assign bresp   = s_q.bresp;
	assign rvalid  = s_q.rvalid;
	assign rdata   = s_q.rdata;
	assign rresp   = s_q.rresp;
	assign exec_busy   = (s_q.st == exec_pkg::st_run);
	assign exec_done   = s_q.done;
	assign irq_service = s_q.mode[exec_pkg::MODE_GIE] && (|s_q.pend);
	assign commit = exec_busy && (s_q.cnt == exec_pkg::CNT_ZERO);
	assign start  = wr_go && (awaddr == exec_pkg::ADDR_CMD) && !exec_busy
		&& (decode(wdata[7:0]) != exec_pkg::op_none);

	function automatic exec_pkg::op_t decode(input logic [7:0] opc);
		exec_pkg::op_t o;
		o = exec_pkg::op_none;
		case (opc)
			exec_pkg::OPC_DA_R, exec_pkg::OPC_DA_IR: o = exec_pkg::bcd_adjust_op;
			exec_pkg::OPC_DEC_R, exec_pkg::OPC_DEC_IR: o = exec_pkg::minus_one_byte_op;
			exec_pkg::OPC_MINUS_ONE_WORD_OP_RR, exec_pkg::OPC_MINUS_ONE_WORD_OP_IR: o = exec_pkg::minus_one_word_op;
			exec_pkg::OPC_IOFF: o = exec_pkg::interrupt_off_op;
			exec_pkg::OPC_DIV_R, exec_pkg::OPC_DIV_IR, exec_pkg::OPC_DIV_IM: o = exec_pkg::divide_op;
			default: begin
				if (opc[3:0] == exec_pkg::OPC_LOOP_LO)
					o = exec_pkg::count_loop_branch_op;
			end
		endcase
		return o;
	endfunction

	////////////////////////////////////////////////////////////////////
	// datapath: operands are frozen while busy, so results use them at commit
	always_comb begin
		hi    = s_q.dst[7:4];
		lo    = s_q.dst[3:0];
		adj   = exec_pkg::ADJ_00;
		adj_c = 1'b0;
		if (!s_q.flags[exec_pkg::FLAG_D]) begin
			if (!s_q.flags[exec_pkg::FLAG_C]) begin
				if (!s_q.flags[exec_pkg::FLAG_H]) begin
					if (hi <= exec_pkg::NIB_9 && lo <= exec_pkg::NIB_9) begin
						adj = exec_pkg::ADJ_00;
					end else if (hi <= exec_pkg::NIB_8 && lo >= exec_pkg::NIB_A) begin
						adj = exec_pkg::ADJ_06;
					end else if (hi >= exec_pkg::NIB_A && lo <= exec_pkg::NIB_9) begin
						adj   = exec_pkg::ADJ_60;
						adj_c = 1'b1;
					end else if (hi >= exec_pkg::NIB_9 && lo >= exec_pkg::NIB_A) begin
						adj   = exec_pkg::ADJ_66;
						adj_c = 1'b1;
					end
				end else if (lo <= exec_pkg::NIB_3) begin
					if (hi <= exec_pkg::NIB_9) begin
						adj = exec_pkg::ADJ_06;
					end else begin
						adj   = exec_pkg::ADJ_66;
						adj_c = 1'b1;
					end
				end
			end else if (!s_q.flags[exec_pkg::FLAG_H]) begin
				if (hi <= exec_pkg::NIB_2) begin
					adj   = (lo <= exec_pkg::NIB_9) ? exec_pkg::ADJ_60 : exec_pkg::ADJ_66;
					adj_c = 1'b1;
				end
			end else if (hi <= exec_pkg::NIB_3 && lo <= exec_pkg::NIB_3) begin
				adj   = exec_pkg::ADJ_66;
				adj_c = 1'b1;
			end
		end else begin
			// the decimal flag marks the previous operation as a subtraction
			if (!s_q.flags[exec_pkg::FLAG_C] && s_q.flags[exec_pkg::FLAG_H]
				&& hi <= exec_pkg::NIB_8 && lo >= exec_pkg::NIB_6) begin
				adj = exec_pkg::ADJ_FA;
			end else if (s_q.flags[exec_pkg::FLAG_C] && !s_q.flags[exec_pkg::FLAG_H]
				&& hi >= exec_pkg::NIB_7 && lo <= exec_pkg::NIB_9) begin
				adj   = exec_pkg::ADJ_A0;
				adj_c = 1'b1;
			end else if (s_q.flags[exec_pkg::FLAG_C] && s_q.flags[exec_pkg::FLAG_H]
				&& hi >= exec_pkg::NIB_6 && lo >= exec_pkg::NIB_6) begin
				adj   = exec_pkg::ADJ_9A;
				adj_c = 1'b1;
			end
		end
		da_res   = s_q.dst[7:0] + adj;
		byte_res = s_q.dst[7:0] - 8'h01;
		word_res = s_q.dst - 16'h0001;
		// a zero divisor is replaced to keep the divider free of x
		divisor  = (s_q.src == exec_pkg::ADJ_00) ? 8'h01 : s_q.src;
		quo      = s_q.dst / {8'h00, divisor};
		rem      = s_q.dst % {8'h00, divisor};
		jump_pc  = s_q.pc + {{8{s_q.src[7]}}, s_q.src};
	end

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				m[i*8 +: 8] = nw[i*8 +: 8];
		end
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		wmerge = 32'h0000_0000;
		s_d.pend = s_q.pend | irq_request;
		if (s_q.bvalid && bready)
			s_d.bvalid = 1'b0;
		if (s_q.rvalid && rready)
			s_d.rvalid = 1'b0;

		if (wr_go) begin
			s_d.bvalid = 1'b1;
			s_d.bresp  = exec_pkg::RESP_OKAY;
			case (awaddr)
				exec_pkg::ADDR_CMD: begin
					if (!exec_busy) begin
						s_d.op      = decode(wdata[7:0]);
						s_d.illegal = (s_d.op == exec_pkg::op_none);
					end
				end
				// operand writes during execution are dropped, keeping inputs stable
				exec_pkg::ADDR_DST: begin
					wmerge = merge({16'h0000, s_q.dst}, wdata, wstrb);
					if (!exec_busy)
						s_d.dst = wmerge[15:0];
				end
				exec_pkg::ADDR_SRC: begin
					wmerge = merge({24'h000000, s_q.src}, wdata, wstrb);
					if (!exec_busy)
						s_d.src = wmerge[7:0];
				end
				exec_pkg::ADDR_FLAGS: begin
					wmerge = merge({24'h000000, s_q.flags}, wdata, wstrb);
					if (!exec_busy)
						s_d.flags = wmerge[7:0];
				end
				exec_pkg::ADDR_PC: begin
					wmerge = merge({16'h0000, s_q.pc}, wdata, wstrb);
					if (!exec_busy)
						s_d.pc = wmerge[15:0];
				end
				exec_pkg::ADDR_MODE: begin
					wmerge = merge({24'h000000, s_q.mode}, wdata, wstrb);
					s_d.mode = wmerge[7:0];
				end
				exec_pkg::ADDR_PEND: begin
					// write one to clear; a request in the same cycle wins
					if (wstrb[0])
						s_d.pend = (s_q.pend & ~wdata[7:0]) | irq_request;
				end
				exec_pkg::ADDR_STATUS: ;
				default: s_d.bresp = exec_pkg::RESP_SLVERR;
			endcase
		end

		if (rd_go) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = exec_pkg::RESP_OKAY;
			case (araddr)
				exec_pkg::ADDR_CMD:    s_d.rdata = {29'h0, s_q.op};
				exec_pkg::ADDR_DST:    s_d.rdata = {16'h0000, s_q.dst};
				exec_pkg::ADDR_SRC:    s_d.rdata = {24'h000000, s_q.src};
				exec_pkg::ADDR_FLAGS:  s_d.rdata = {24'h000000, s_q.flags};
				exec_pkg::ADDR_PC:     s_d.rdata = {16'h0000, s_q.pc};
				exec_pkg::ADDR_MODE:   s_d.rdata = {24'h000000, s_q.mode};
				exec_pkg::ADDR_PEND:   s_d.rdata = {24'h000000, s_q.pend};
				exec_pkg::ADDR_STATUS: s_d.rdata = {19'h0, s_q.cnt, 2'h0,
					s_q.len, 2'h0, s_q.illegal, exec_busy};
				default: begin
					s_d.rdata = 32'h0000_0000;
					s_d.rresp = exec_pkg::RESP_SLVERR;
				end
			endcase
		end

		case (s_q.st)
			exec_pkg::st_idle: begin
				if (start) begin
					s_d.st = exec_pkg::st_run;
					case (s_d.op)
						exec_pkg::bcd_adjust_op: begin
							s_d.cnt = exec_pkg::CYC_BYTE - exec_pkg::CNT_STEP;
							s_d.len = exec_pkg::LEN_2;
						end
						exec_pkg::minus_one_byte_op: begin
							s_d.cnt = exec_pkg::CYC_BYTE - exec_pkg::CNT_STEP;
							s_d.len = exec_pkg::LEN_2;
						end
						exec_pkg::minus_one_word_op: begin
							s_d.cnt = exec_pkg::CYC_WORD - exec_pkg::CNT_STEP;
							s_d.len = exec_pkg::LEN_2;
						end
						exec_pkg::interrupt_off_op: begin
							s_d.cnt = exec_pkg::CYC_IOFF - exec_pkg::CNT_STEP;
							s_d.len = exec_pkg::LEN_1;
						end
						exec_pkg::divide_op: begin
							s_d.cnt = ((s_q.src == exec_pkg::ADJ_00) ? exec_pkg::CYC_DIV0
								: exec_pkg::CYC_DIV) - exec_pkg::CNT_STEP;
							s_d.len = exec_pkg::LEN_3;
						end
						default: begin
							s_d.cnt = exec_pkg::CYC_LOOP - exec_pkg::CNT_STEP;
							s_d.len = exec_pkg::LEN_2;
						end
					endcase
				end
			end
			exec_pkg::st_run: begin
				if (commit) begin
					s_d.st   = exec_pkg::st_idle;
					s_d.done = 1'b1;
					case (s_q.op)
						exec_pkg::bcd_adjust_op: begin
							s_d.dst[7:0] = da_res;
							s_d.flags[exec_pkg::FLAG_C] = adj_c;
							s_d.flags[exec_pkg::FLAG_Z] = (da_res == exec_pkg::ADJ_00);
							s_d.flags[exec_pkg::FLAG_S] = da_res[7];
						end
						exec_pkg::minus_one_byte_op: begin
							s_d.dst[7:0] = byte_res;
							s_d.flags[exec_pkg::FLAG_Z] = (byte_res == exec_pkg::ADJ_00);
							s_d.flags[exec_pkg::FLAG_S] = byte_res[7];
							s_d.flags[exec_pkg::FLAG_V] = (s_q.dst[7:0] == exec_pkg::BYTE_MIN);
						end
						exec_pkg::minus_one_word_op: begin
							s_d.dst = word_res;
							s_d.flags[exec_pkg::FLAG_Z] = (word_res == 16'h0000);
							s_d.flags[exec_pkg::FLAG_S] = word_res[15];
							s_d.flags[exec_pkg::FLAG_V] = (s_q.dst == exec_pkg::WORD_MIN);
						end
						exec_pkg::interrupt_off_op: begin
							s_d.mode[exec_pkg::MODE_GIE] = 1'b0;
						end
						exec_pkg::divide_op: begin
							if (s_q.src == exec_pkg::ADJ_00) begin
								// destination left as it was on a zero divisor
								s_d.flags[exec_pkg::FLAG_V] = 1'b1;
								s_d.flags[exec_pkg::FLAG_Z] = 1'b1;
								s_d.flags[exec_pkg::FLAG_C] = 1'b0;
								s_d.flags[exec_pkg::FLAG_S] = 1'b0;
							end else begin
								s_d.dst = {rem[7:0], quo[7:0]};
								s_d.flags[exec_pkg::FLAG_V] = (quo >= exec_pkg::QUO_OVF);
								s_d.flags[exec_pkg::FLAG_C] = (quo >= exec_pkg::QUO_OVF)
									&& (quo < exec_pkg::QUO_CARRY);
								s_d.flags[exec_pkg::FLAG_Z] = (quo == 16'h0000);
								s_d.flags[exec_pkg::FLAG_S] = quo[7];
							end
						end
						default: begin
							s_d.dst[7:0] = byte_res;
							if (byte_res != exec_pkg::ADJ_00)
								s_d.pc = jump_pc;
						end
					endcase
				end else begin
					s_d.cnt = s_q.cnt - exec_pkg::CNT_STEP;
				end
			end
			default: s_d.st = exec_pkg::st_idle;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q       <= '0;
			s_q.st    <= exec_pkg::st_idle;
			s_q.op    <= exec_pkg::op_none;
			s_q.mode  <= exec_pkg::MODE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_da_add_06;
		commit && s_q.op == exec_pkg::bcd_adjust_op && s_q.flags[7:2] == 6'h00
			&& s_q.dst[7:4] <= 4'h8 && s_q.dst[3:0] >= 4'ha
		|=> s_q.dst[7:0] == $past(s_q.dst[7:0]) + 8'h06 && !s_q.flags[7];
	endproperty
	a_da_add_06: assert property (p_da_add_06) else $error("adjust 06 wrong");

	property p_da_sub_9a;
		commit && s_q.op == exec_pkg::bcd_adjust_op && s_q.flags[7]
			&& s_q.flags[3] && s_q.flags[2]
			&& s_q.dst[7:4] >= 4'h6 && s_q.dst[3:0] >= 4'h6
		|=> s_q.dst[7:0] == $past(s_q.dst[7:0]) + 8'h9a;
	endproperty
	a_da_sub_9a: assert property (p_da_sub_9a) else $error("adjust 9a wrong");

	property p_da_carry;
		commit && s_q.op == exec_pkg::bcd_adjust_op && s_q.flags[7:2] == 6'h00
			&& s_q.dst[7:4] >= 4'ha && s_q.dst[3:0] <= 4'h9
		|=> s_q.flags[7];
	endproperty
	a_da_carry: assert property (p_da_carry) else $error("adjust carry lost");

	property p_da_flags;
		commit && s_q.op == exec_pkg::bcd_adjust_op
		|=> s_q.flags[6] == (s_q.dst[7:0] == 8'h00) && s_q.flags[5] == s_q.dst[7]
			&& $stable(s_q.flags[3:2]);
	endproperty
	a_da_flags: assert property (p_da_flags) else $error("adjust flags wrong");

	property p_dec_byte;
		commit && s_q.op == exec_pkg::minus_one_byte_op
		|=> s_q.dst[7:0] == $past(s_q.dst[7:0]) - 8'h01 && $stable(s_q.flags[7])
			&& s_q.flags[4] == ($past(s_q.dst[7:0]) == 8'h80);
	endproperty
	a_dec_byte: assert property (p_dec_byte) else $error("byte decrement wrong");

	property p_dec_word;
		commit && s_q.op == exec_pkg::minus_one_word_op
		|=> s_q.dst == $past(s_q.dst) - 16'h0001 && $stable(s_q.flags[7])
			&& s_q.flags[6] == (s_q.dst == 16'h0000);
	endproperty
	a_dec_word: assert property (p_dec_word) else $error("word decrement wrong");

	property p_ioff;
		commit && s_q.op == exec_pkg::interrupt_off_op |=> !irq_service;
	endproperty
	a_ioff: assert property (p_ioff) else $error("interrupts still on");

	property p_pend_kept;
		irq_request[0] && !s_q.mode[0]
			&& !(wr_go && awaddr == exec_pkg::ADDR_MODE)
		|=> s_q.pend[0] && !irq_service;
	endproperty
	a_pend_kept: assert property (p_pend_kept) else $error("request mishandled");

	property p_div_zero;
		start && s_d.op == exec_pkg::divide_op && s_q.src == 8'h00
		|-> ##10 commit ##1 s_q.flags[4] && s_q.flags[6] && !s_q.flags[7];
	endproperty
	a_div_zero: assert property (p_div_zero) else $error("zero divide wrong");

	property p_div_time;
		start && s_d.op == exec_pkg::divide_op && s_q.src != 8'h00
		|-> !commit [*8] ##19 commit;
	endproperty
	a_div_time: assert property (p_div_time) else $error("divide time wrong");

	property p_loop;
		commit && s_q.op == exec_pkg::count_loop_branch_op && s_q.dst[7:0] != 8'h01
		|=> s_q.pc == $past(s_q.pc) + {{8{$past(s_q.src[7])}}, $past(s_q.src)}
			&& $stable(s_q.flags);
	endproperty
	a_loop: assert property (p_loop) else $error("loop branch wrong");

	c_div: cover property (commit && s_q.op == exec_pkg::divide_op);
	c_loop: cover property (commit && s_q.op == exec_pkg::count_loop_branch_op);
	c_da: cover property (commit && s_q.op == exec_pkg::bcd_adjust_op && adj_c);
	c_svc: cover property (irq_service);

endmodule

// ==== tb/irq_src.sv ====
`timescale 1ns/1ns

// core-side request source: one-cycle pulses, so pending bits must latch
module irq_src (
	// clock
	input  wire logic       aclk,
	// request control
	input  wire logic       fire,
	input  wire logic [7:0] lines,
	// to block
	output logic      [7:0] irq_request = 8'h00
);
	always @(posedge aclk) begin
		irq_request <= fire ? lines : 8'h00;
	end
endmodule

// ==== tb/tb_cpu_bcd_dec_div_loop_exec.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
	$display("Error %0t: got %h exp %h", $time, (a), (b)); end end

module tb_cpu_bcd_dec_div_loop_exec;
	logic        aclk = 1'b0, aresetn = 1'b0, fire = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, lines = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hf;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        irq_service, exec_busy, exec_done;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, r;
	logic [7:0]  irq_request, fm = 8'hff;
	logic [15:0] dm = 16'hffff;
	logic [4:0]  busy_n = 5'h00;
	int          n_fail = 0, checked = 0;

	cpu_bcd_dec_div_loop_exec dut_u (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready),
		.irq_request(irq_request), .irq_service(irq_service),
		.exec_busy(exec_busy), .exec_done(exec_done)
	);
	irq_src src_u (.aclk(aclk), .fire(fire), .lines(lines),
		.irq_request(irq_request));

	initial begin
		forever #10 aclk = ~aclk;
	end
	// counts busy cycles; cleared only while idle, so no clash with the edge
	always @(posedge aclk) begin
		if (exec_busy === 1'b1) busy_n <= busy_n + 5'h01;
	end

	////////////////////////////////////////////////////////////////////
	task close_out();
		$display("checked %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e = 2'h0);
		awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk); while (awready !== 1'b1);
		awvalid <= 1'b0; wvalid <= 1'b0;
		// bready stays up: lowering it here would clash with the next call
		do @(posedge aclk); while (bvalid !== 1'b1);
		`CHK(bresp, e)
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] e = 2'h0);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		`CHK(rresp, e)
	endtask
	// loads operands, runs one opcode, checks busy cycle count, result and flags
	task tx(input logic [7:0] op, input logic [15:0] d, input logic [7:0] s,
		input logic [7:0] f, input logic [15:0] ed, input logic [7:0] ef,
		input logic [4:0] n);
		int k;
		wr(exec_pkg::ADDR_DST, {16'h0000, d});
		wr(exec_pkg::ADDR_SRC, {24'h0, s});
		wr(exec_pkg::ADDR_FLAGS, {24'h0, f});
		busy_n = 5'h00;
		wr(exec_pkg::ADDR_CMD, {24'h0, op});
		for (k = 0; k < 40 && exec_done !== 1'b1; k++) @(posedge aclk);
		`CHK(exec_done, 1'b1)
		`CHK(busy_n, n)
		rd(exec_pkg::ADDR_DST, r);
		`CHK(r[15:0] & dm, ed & dm)
		rd(exec_pkg::ADDR_FLAGS, r);
		`CHK(r[7:0] & fm, ef & fm)
	endtask
	task pulse(input logic [7:0] v);
		lines <= v; fire <= 1'b1;
		@(posedge aclk);
		fire <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask

	////////////////////////////////////////////////////////////////////
	// overflow is undefined here, so it is masked out
	task bcd_adjust();
		fm = 8'hec;
		tx(8'h40, 16'h3c, 8'h0, 8'h00, 16'h42, 8'h00, 5'h04);
		tx(8'h41, 16'ha3, 8'h0, 8'h00, 16'h03, 8'h80, 5'h04);
		tx(8'h40, 16'h9a, 8'h0, 8'h00, 16'h00, 8'hc0, 5'h04);
		tx(8'h41, 16'h2f, 8'h0, 8'h0c, 16'h29, 8'h0c, 5'h04);
		tx(8'h40, 16'h85, 8'h0, 8'h88, 16'h25, 8'h88, 5'h04);
		tx(8'h41, 16'h66, 8'h0, 8'h8c, 16'h00, 8'hcc, 5'h04);
		fm = 8'hff;
	endtask
	task decrements();
		tx(8'h00, 16'h80, 8'h0, 8'h8c, 16'h7f, 8'h9c, 5'h04);
		tx(8'h01, 16'h00, 8'h0, 8'h00, 16'hff, 8'h20, 5'h04);
		tx(8'h00, 16'h01, 8'h0, 8'h00, 16'h00, 8'h40, 5'h04);
		tx(8'h80, 16'h0, 8'h0, 8'h0c, 16'hffff, 8'h2c, 5'h08);
		tx(8'h81, 16'h8000, 8'h0, 8'h80, 16'h7fff, 8'h90, 5'h08);
		tx(8'h80, 16'h0100, 8'h0, 8'h00, 16'h00ff, 8'h00, 5'h08);
	endtask
	task divide();
		tx(8'h94, 16'h1003, 8'h40, 8'h0c, 16'h0340, 8'h0c, 5'h1a);
		tx(8'h95, 16'h1003, 8'h00, 8'h00, 16'h1003, 8'h50, 5'h0a);
		tx(8'h96, 16'h0080, 8'h01, 8'h00, 16'h0080, 8'h20, 5'h1a);
		tx(8'h94, 16'h0005, 8'h10, 8'h00, 16'h0500, 8'h40, 5'h1a);
		// stored halves are meaningless once the quotient overflows
		dm = 16'h0000;
		tx(8'h95, 16'h0100, 8'h01, 8'h00, 16'h0, 8'h90, 5'h1a);
		tx(8'h96, 16'h0200, 8'h01, 8'h00, 16'h0, 8'h10, 5'h1a);
		dm = 16'hffff;
	endtask
	task count_loop();
		wr(exec_pkg::ADDR_PC, 32'h0100);
		// counter kept in dst, as if the program had set the bank
		tx(8'h1a, 16'h02, 8'hfe, 8'hfc, 16'h01, 8'hfc, 5'h08);
		rd(exec_pkg::ADDR_PC, r);
		`CHK(r[15:0], 16'h00fe)
		tx(8'h3a, 16'h01, 8'hfe, 8'h00, 16'h00, 8'h00, 5'h08);
		rd(exec_pkg::ADDR_PC, r);
		`CHK(r[15:0], 16'h00fe)
		tx(8'hfa, 16'h00, 8'h7f, 8'h00, 16'hff, 8'h00, 5'h08);
		rd(exec_pkg::ADDR_PC, r);
		`CHK(r[15:0], 16'h017d)
	endtask
	task interrupt_off();
		rd(exec_pkg::ADDR_MODE, r);
		`CHK(r[7:0], exec_pkg::MODE_RESET)
		wr(exec_pkg::ADDR_MODE, 32'h1);
		pulse(8'h04);
		`CHK(irq_service, 1'b1)
		tx(8'h8f, 16'h55, 8'h00, 8'h00, 16'h55, 8'h00, 5'h04);
		rd(exec_pkg::ADDR_MODE, r);
		`CHK(r[0], 1'b0)
		`CHK(irq_service, 1'b0)
		pulse(8'h11);
		rd(exec_pkg::ADDR_PEND, r);
		`CHK(r[7:0], 8'h15)
		`CHK(irq_service, 1'b0)
	endtask
	// unmapped place answers with an error and reads as zero
	task unmapped();
		wr(8'h40, 32'h1, exec_pkg::RESP_SLVERR);
		rd(8'h40, r, exec_pkg::RESP_SLVERR);
		`CHK(r, 32'h0)
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		interrupt_off();
		bcd_adjust();
		decrements();
		divide();
		count_loop();
		unmapped();
		close_out();
	end
	// about 500 cycles expected; eightfold margin
	initial begin
		#80000;
		n_fail++;
		close_out();
	end
endmodule
